//--- rtl/charger_alert_status_logic.sv
// alert latches, alert line and system status word of the charger management port
// Function
// - latch input voltage low flag, bit 9
// - latch input voltage high flag, bit 8
// - latch system voltage low/high, bits 7/6
// - latch input current high flag, bit 5
// - latch battery current low flag, bit 4
// - latch die temperature, series resistance, bits 3/2
// - latch thermistor cold bit 1, hot bit 0
// - phase alert on enabled state entry, or re-raised by a clear while the phase holds
// - alert bits stay until disabled or cleared
// - writing zero to a bit clears it
// - clear with its condition holding re-raises alert, limits as judged at the last tick
// - new alert pulls line low until response
// - phase alert bit map, equalize 10 down to short 0
// - loop alerts: undervoltage, input, current, voltage
// - status bit 13 while charging
// - status bit 11 follows tracking pin
// - status bit 10 after equalize pin rise
// - status bits 9 and 1 show supplies good, clear of their lockouts
// - status bit 8 cell error, 5 resistor absent
// - status bit 6 when charging permitted
// - status bit 2 input above battery
// - status bit 4 thermal, bit 3 overvoltage
// - limit alerts evaluated once per measurement cycle
`include "charger_alert_params.svh"

module charger_alert_status_logic #(
  parameter int MEAS_CYCLE_CYCLES = `MEAS_CYCLE_NS / `CLK_PERIOD_NS
) (
  input wire logic clk,
  input wire logic rstn,
  // register port from the serial engine
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [`ADDR_W-1:0] reg_addr,
  input wire logic [`DATA_W-1:0] reg_wdata,
  output logic [`DATA_W-1:0] reg_rdata_ff,
  // alert response completed by the serial engine
  input wire logic ara_done,
  // open-drain alert line
  output logic smbalert_o_ff,
  output logic smbalert_oe_ff,
  // measurement limit crossings, level, from the converter compare stage
  input wire logic input_voltage_below_limit,
  input wire logic input_voltage_above_limit,
  input wire logic system_voltage_below_limit,
  input wire logic system_voltage_above_limit,
  input wire logic input_current_above_limit,
  input wire logic battery_current_below_limit,
  input wire logic chip_temperature_above_limit,
  input wire logic series_resistance_above_limit,
  input wire logic thermistor_ratio_above_limit,
  input wire logic thermistor_ratio_below_limit,
  input wire logic [`UPPER_W-1:0] upper_limit_crossed,
  // charger phase, one-hot, and regulation loop in control
  input wire logic [`PHASE_W-1:0] charger_phase,
  input wire logic [`LOOP_W-1:0] regulation_loop,
  // real-time system conditions
  input wire logic charging_active,
  input wire logic tracking_pin,
  input wire logic equalize_request_pin,
  input wire logic equalize_finished,
  input wire logic drive_supply_good,
  input wire logic cell_count_invalid,
  input wire logic charging_permitted,
  input wire logic frequency_resistor_absent,
  input wire logic thermal_shutdown,
  input wire logic input_overvoltage,
  input wire logic input_above_battery,
  input wire logic internal_supply_above_switch_uvlo,
  input wire logic meas_supply_good
);
  localparam int CNT_W = $clog2(MEAS_CYCLE_CYCLES + 1);

  // ==========================================================
  // address decode helper, shared by read and write paths
  function automatic logic addr_hit(input logic [`ADDR_W-1:0] a,
                                    input logic [`ADDR_W-1:0] off);
    addr_hit = (a == off);
  endfunction

  // ==========================================================
  // measurement cycle divider
  logic [CNT_W-1:0] meas_cnt_ff; // cycles into the current measurement cycle
  logic meas_tick_ff;            // one-cycle enable at each cycle end

  // free-running divider; the tick marks where limits are judged
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meas_cnt_ff <= '0;
      meas_tick_ff <= 1'b0;
    end else if (meas_cnt_ff == CNT_W'(MEAS_CYCLE_CYCLES - 1)) begin
      meas_cnt_ff <= '0;
      meas_tick_ff <= 1'b1;
    end else begin
      meas_cnt_ff <= meas_cnt_ff + CNT_W'(1);
      meas_tick_ff <= 1'b0;
    end
  end

  // ==========================================================
  // limit crossing vector
  logic [`LIMIT_W-1:0] limit_now;  // crossings as seen right now
  logic [`LIMIT_W-1:0] limit_seen_ff; // crossings judged at the last tick

  // gather crossings into their alert bit positions
  always_comb begin
    limit_now = '0;
    limit_now[`LIM_VIN_LO] = input_voltage_below_limit;
    limit_now[`LIM_VIN_HI] = input_voltage_above_limit;
    limit_now[`LIM_VSYS_LO] = system_voltage_below_limit;
    limit_now[`LIM_VSYS_HI] = system_voltage_above_limit;
    limit_now[`LIM_IIN_HI] = input_current_above_limit;
    limit_now[`LIM_IBAT_LO] = battery_current_below_limit;
    limit_now[`LIM_DIE_HI] = chip_temperature_above_limit;
    limit_now[`LIM_BSR_HI] = series_resistance_above_limit;
    limit_now[`LIM_NTC_COLD] = thermistor_ratio_above_limit;
    limit_now[`LIM_NTC_HOT] = thermistor_ratio_below_limit;
    limit_now[`LIMIT_W-1:`LIM_UPPER_LSB] = upper_limit_crossed;
    limit_now = limit_now & `LIMIT_USED_MASK; // reserved bit never alerts
  end

  // the re-raise on clear uses the last judged crossing, not the live
  // compare, so a limit only ever acts at measurement cycle granularity
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      limit_seen_ff <= '0;
    end else if (meas_tick_ff) begin
      limit_seen_ff <= limit_now;
    end
  end

  // ==========================================================
  // phase and regulation loop entry detection
  logic [`PHASE_W-1:0] phase_prev_ff;
  logic [`LOOP_W-1:0] loop_prev_ff;

  // previous values; inputs are already synchronous to clk
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      phase_prev_ff <= '0;
      loop_prev_ff <= '0;
    end else begin
      phase_prev_ff <= charger_phase;
      loop_prev_ff <= regulation_loop;
    end
  end

  // ==========================================================
  // enable words, one per alert word
  logic [`LIMIT_W-1:0] en_limit_ff;
  logic [`PHASE_W-1:0] en_phase_ff;
  logic [`LOOP_W-1:0] en_loop_ff;

  // enable bits sit at the same positions as their alert bits
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      en_limit_ff <= `EN_LIMIT_RST;
      en_phase_ff <= `EN_PHASE_RST;
      en_loop_ff <= `EN_LOOP_RST;
    end else if (reg_wr) begin
      if (addr_hit(reg_addr, `OFF_EN_LIMIT)) begin
        en_limit_ff <= reg_wdata & `LIMIT_USED_MASK;
      end
      if (addr_hit(reg_addr, `OFF_EN_PHASE)) begin
        en_phase_ff <= reg_wdata[`PHASE_W-1:0];
      end
      if (addr_hit(reg_addr, `OFF_EN_LOOP)) begin
        en_loop_ff <= reg_wdata[`LOOP_W-1:0];
      end
    end
  end

  // ==========================================================
  // latch banks
  alert_bank_if #(.W(`LIMIT_W)) limit_bus ();
  alert_bank_if #(.W(`PHASE_W)) phase_bus ();
  alert_bank_if #(.W(`LOOP_W)) loop_bus ();

  // limit bank: triggered only at the tick
  assign limit_bus.en = en_limit_ff;
  assign limit_bus.cond = limit_seen_ff;
  assign limit_bus.trig = meas_tick_ff ? limit_now : '0;
  // writing a one leaves a bit alone, writing a zero clears it
  assign limit_bus.clr =
    (reg_wr && addr_hit(reg_addr, `OFF_LIMIT_ALERTS)) ? ~reg_wdata : '0;

  // phase bank: entry into a phase, bit order as the phase word
  assign phase_bus.en = en_phase_ff;
  assign phase_bus.cond = charger_phase;
  assign phase_bus.trig = charger_phase & ~phase_prev_ff;
  assign phase_bus.clr = (reg_wr && addr_hit(reg_addr, `OFF_PHASE_ALERTS)) ?
    ~reg_wdata[`PHASE_W-1:0] : '0;

  // loop bank: a loop taking control
  assign loop_bus.en = en_loop_ff;
  assign loop_bus.cond = regulation_loop;
  assign loop_bus.trig = regulation_loop & ~loop_prev_ff;
  assign loop_bus.clr = (reg_wr && addr_hit(reg_addr, `OFF_LOOP_ALERTS)) ?
    ~reg_wdata[`LOOP_W-1:0] : '0;

  alert_latch_bank #(.W(`LIMIT_W)) u_limit_bank (
    .clk(clk),
    .rstn(rstn),
    .bank_io(limit_bus.bank)
  );
  alert_latch_bank #(.W(`PHASE_W)) u_phase_bank (
    .clk(clk),
    .rstn(rstn),
    .bank_io(phase_bus.bank)
  );
  alert_latch_bank #(.W(`LOOP_W)) u_loop_bank (
    .clk(clk),
    .rstn(rstn),
    .bank_io(loop_bus.bank)
  );

  // ==========================================================
  // alert line
  charger_alert_pkg::line_state_t line_ff;
  charger_alert_pkg::line_state_t nxt_line;
  logic any_new; // some bank raised a bit

  // a new alert wins over a response finishing in the same cycle,
  // so no alert slips past the host unannounced
  always_comb begin
    any_new = limit_bus.new_alert | phase_bus.new_alert | loop_bus.new_alert;
    case (line_ff)
      charger_alert_pkg::LINE_IDLE: begin
        nxt_line = any_new ? charger_alert_pkg::LINE_LOW
                           : charger_alert_pkg::LINE_IDLE;
      end
      charger_alert_pkg::LINE_LOW: begin
        nxt_line = (ara_done && !any_new) ? charger_alert_pkg::LINE_IDLE
                                          : charger_alert_pkg::LINE_LOW;
      end
      default: begin
        nxt_line = charger_alert_pkg::LINE_IDLE;
      end
    endcase
  end

  // state and pin drivers; the pin only ever sinks, so output stays low
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      line_ff <= charger_alert_pkg::LINE_IDLE;
      smbalert_o_ff <= 1'b0;
      smbalert_oe_ff <= 1'b0;
    end else begin
      line_ff <= nxt_line;
      smbalert_o_ff <= 1'b0;
      smbalert_oe_ff <= (nxt_line == charger_alert_pkg::LINE_LOW);
    end
  end

  // ==========================================================
  // system status word
  logic eq_req_ff;   // equalize queued or running
  logic eq_pin_prev_ff;
  logic [`STATUS_W-1:0] status_ff;

  // equalize request: caught on a pin rise, held until equalize_finished
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      eq_pin_prev_ff <= 1'b0;
      eq_req_ff <= 1'b0;
    end else begin
      eq_pin_prev_ff <= equalize_request_pin;
      if (equalize_request_pin && !eq_pin_prev_ff) begin
        eq_req_ff <= 1'b1;
      end else if (equalize_finished) begin
        eq_req_ff <= 1'b0;
      end
    end
  end

  // real-time view, one register stage behind the conditions
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      status_ff <= '0;
    end else begin
      status_ff <= '0;
      status_ff[`ST_CHARGING] <= charging_active;
      status_ff[`ST_TRACKING] <= tracking_pin;
      status_ff[`ST_EQ_REQ] <= eq_req_ff;
      status_ff[`ST_DRV_GOOD] <= drive_supply_good;
      status_ff[`ST_CELL_ERR] <= cell_count_invalid;
      status_ff[`ST_PERMIT] <= charging_permitted;
      status_ff[`ST_NO_FREQ_RES] <= frequency_resistor_absent;
      status_ff[`ST_THERMAL_SD] <= thermal_shutdown;
      status_ff[`ST_IN_OVLO] <= input_overvoltage;
      status_ff[`ST_IN_ABOVE_BAT] <= input_above_battery;
      status_ff[`ST_INT_SUPPLY] <= internal_supply_above_switch_uvlo;
      status_ff[`ST_MEAS_SUPPLY] <= meas_supply_good;
    end
  end

  // ==========================================================
  // read path
  // one-cycle read latency; unmapped addresses read as zero
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata_ff <= '0;
    end else if (reg_rd) begin
      if (addr_hit(reg_addr, `OFF_LIMIT_ALERTS)) begin
        reg_rdata_ff <= limit_bus.flags;
      end else if (addr_hit(reg_addr, `OFF_PHASE_ALERTS)) begin
        reg_rdata_ff <= `DATA_W'(phase_bus.flags);
      end else if (addr_hit(reg_addr, `OFF_LOOP_ALERTS)) begin
        reg_rdata_ff <= `DATA_W'(loop_bus.flags);
      end else if (addr_hit(reg_addr, `OFF_SYS_STATUS)) begin
        reg_rdata_ff <= `DATA_W'(status_ff);
      end else if (addr_hit(reg_addr, `OFF_EN_LIMIT)) begin
        reg_rdata_ff <= en_limit_ff;
      end else if (addr_hit(reg_addr, `OFF_EN_PHASE)) begin
        reg_rdata_ff <= `DATA_W'(en_phase_ff);
      end else if (addr_hit(reg_addr, `OFF_EN_LOOP)) begin
        reg_rdata_ff <= `DATA_W'(en_loop_ff);
      end else begin
        reg_rdata_ff <= '0;
      end
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  // a limit bit only rises at a tick or a re-raise after a clear
  a_limit_at_tick: assert property (
    ((limit_bus.flags & ~$past(limit_bus.flags)) != '0) |->
      ($past(meas_tick_ff) || ($past(limit_bus.clr) != '0)))
    else $error("limit alert rose outside a measurement tick");
  a_tick_period: assert property ($rose(meas_tick_ff) |=> !meas_tick_ff)
    else $error("measurement tick longer than one cycle");
  a_vin_low_latch: assert property (
    (meas_tick_ff && input_voltage_below_limit && en_limit_ff[`LIM_VIN_LO]) |=>
      limit_bus.flags[`LIM_VIN_LO])
    else $error("input voltage low flag not latched");
  a_cold_latch: assert property (
    (meas_tick_ff && thermistor_ratio_above_limit && en_limit_ff[`LIM_NTC_COLD]) |=>
      limit_bus.flags[`LIM_NTC_COLD])
    else $error("thermistor cold flag not latched");
  a_phase_entry: assert property (
    ((charger_phase & ~phase_prev_ff & en_phase_ff) != '0) |=>
      ((phase_bus.flags & $past(charger_phase & ~phase_prev_ff & en_phase_ff)) != '0))
    else $error("enabled phase entry did not raise its alert");
  a_loop_entry: assert property (
    ((regulation_loop & ~loop_prev_ff & en_loop_ff) != '0) |=>
      ((loop_bus.flags & $past(regulation_loop & ~loop_prev_ff & en_loop_ff)) != '0))
    else $error("enabled loop takeover did not raise its alert");

  sequence s_bank_raise;
    any_new;
  endsequence
  sequence s_line_pulled;
    ##1 smbalert_oe_ff && !smbalert_o_ff;
  endsequence
  a_line_new_alert: assert property (s_bank_raise |-> s_line_pulled)
    else $error("new alert did not pull the alert line low");
  a_line_hold: assert property ((smbalert_oe_ff && !ara_done) |=> smbalert_oe_ff)
    else $error("alert line released without alert response");
  a_eq_request: assert property (
    (equalize_request_pin && !eq_pin_prev_ff) |=> ##1 status_ff[`ST_EQ_REQ])
    else $error("equalize request not shown after pin rise");
  a_status_charging: assert property (
    charging_active |=> status_ff[`ST_CHARGING] == $past(charging_active))
    else $error("charging status bit does not follow charger");
endmodule

//--- rtl/charger_alert_params.svh
// constants for the charger alert and status logic: offsets, widths, fields, timing
`ifndef CHARGER_ALERT_PARAMS_SVH
`define CHARGER_ALERT_PARAMS_SVH
// ==========================================================
// register port geometry
`define ADDR_W 8
`define DATA_W 16
// ==========================================================
// register sub-addresses
`define OFF_LIMIT_ALERTS 8'h36
`define OFF_PHASE_ALERTS 8'h37
`define OFF_LOOP_ALERTS 8'h38
`define OFF_SYS_STATUS 8'h39
`define OFF_EN_LIMIT 8'h0d
`define OFF_EN_PHASE 8'h0e
`define OFF_EN_LOOP 8'h0f
// ==========================================================
// word widths and masks
`define LIMIT_W 16
`define PHASE_W 11
`define LOOP_W 4
`define STATUS_W 14
`define UPPER_W 6
`define LIMIT_USED_MASK 16'hbfff
`define EN_LIMIT_RST 16'h0000
`define EN_PHASE_RST 11'h000
`define EN_LOOP_RST 4'h0
// ==========================================================
// limit alert bit positions
`define LIM_VIN_LO 9
`define LIM_VIN_HI 8
`define LIM_VSYS_LO 7
`define LIM_VSYS_HI 6
`define LIM_IIN_HI 5
`define LIM_IBAT_LO 4
`define LIM_DIE_HI 3
`define LIM_BSR_HI 2
`define LIM_NTC_COLD 1
`define LIM_NTC_HOT 0
`define LIM_UPPER_LSB 10
// ==========================================================
// system status bit positions
`define ST_CHARGING 13
`define ST_TRACKING 11
`define ST_EQ_REQ 10
`define ST_DRV_GOOD 9
`define ST_CELL_ERR 8
`define ST_PERMIT 6
`define ST_NO_FREQ_RES 5
`define ST_THERMAL_SD 4
`define ST_IN_OVLO 3
`define ST_IN_ABOVE_BAT 2
`define ST_INT_SUPPLY 1
`define ST_MEAS_SUPPLY 0
// ==========================================================
// timing
`define CLK_PERIOD_NS 25
`define MEAS_CYCLE_NS 6500000
`endif

//--- rtl/charger_alert_pkg.sv
// types shared by the charger alert and status logic
package charger_alert_pkg;
  // ==========================================================
  // alert line state, one-hot
  typedef enum logic [1:0] {
    LINE_IDLE = 2'b01,
    LINE_LOW = 2'b10
  } line_state_t;
endpackage

//--- rtl/alert_bank_if.sv
// carrier between the top and one sticky alert latch bank
interface alert_bank_if #(parameter int W = 4);
  logic [W-1:0] en;        // per-bit enables
  logic [W-1:0] cond;      // condition still holding
  logic [W-1:0] trig;      // one-cycle trigger per bit
  logic [W-1:0] clr;       // host clear mask
  logic [W-1:0] flags;     // latched alert bits
  logic new_alert;         // pulse: a bit was raised or re-raised
  // ==========================================================
  // top drives the causes, the bank answers with its flags
  modport owner (output en, output cond, output trig, output clr,
                 input flags, input new_alert);
  modport bank (input en, input cond, input trig, input clr,
                output flags, output new_alert);
endinterface

//--- rtl/alert_latch_bank.sv
// sticky alert latch bank with enable gating, write-zero clear and re-raise
module alert_latch_bank #(
  parameter int W = 4
) (
  input wire logic clk,
  input wire logic rstn,
  alert_bank_if.bank bank_io
);
  // ==========================================================
  // latches
  logic [W-1:0] flags_ff;
  logic [W-1:0] nxt_flags;
  logic [W-1:0] set_bits; // bits raised this cycle
  logic new_ff;

  // set wins over clear; clearing a bit whose condition holds re-raises it
  always_comb begin
    set_bits = bank_io.en & (bank_io.trig | (bank_io.clr & bank_io.cond));
    nxt_flags = bank_io.en & ((flags_ff & ~bank_io.clr) | set_bits);
  end

  // latch update
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      flags_ff <= '0;
    end else begin
      flags_ff <= nxt_flags;
    end
  end

  // new alert: bit goes high, or is re-raised in the cycle it was cleared
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      new_ff <= 1'b0;
    end else begin
      new_ff <= |(set_bits & (~flags_ff | bank_io.clr));
    end
  end

  assign bank_io.flags = flags_ff;
  assign bank_io.new_alert = new_ff;

  // ==========================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  a_disable_release: assert property ((flags_ff & ~$past(bank_io.en)) == '0)
    else $error("alert bit held while disabled");
  a_sticky_hold: assert property (
    ((flags_ff & bank_io.en & ~bank_io.clr) != '0) |=>
      ((flags_ff & $past(flags_ff & bank_io.en & ~bank_io.clr)) != '0))
    else $error("sticky alert bit dropped without clear");
  a_zero_clears: assert property (
    ((bank_io.clr & ~bank_io.cond & ~bank_io.trig) != '0) |=>
      ((flags_ff & $past(bank_io.clr & ~bank_io.cond & ~bank_io.trig)) == '0))
    else $error("write of zero did not clear the alert bit");
  a_reraise: assert property (
    ((bank_io.clr & bank_io.cond & bank_io.en) != '0) |=>
      (((flags_ff & $past(bank_io.clr & bank_io.cond & bank_io.en))
        == $past(bank_io.clr & bank_io.cond & bank_io.en)) && new_ff))
    else $error("cleared alert with live condition was not re-raised");
endmodule

//--- tb/alert_host_model.sv
// smbus host model: answers a pulled-low alert line with a finished alert response
module alert_host_model #(
  parameter int DLY = 6
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic alert_line,
  output logic ara_done
);
  timeunit 1ns;
  timeprecision 100ps;
  int cnt; // cycles the line has been seen low
  // ==========================================================
  // host reacts late, as a busy bus master would, then pulses done once
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt <= 0;
      ara_done <= 1'b0;
    end else begin
      ara_done <= 1'b0;
      if (alert_line || ara_done) begin
        cnt <= 0;
      end else if (cnt == DLY) begin
        ara_done <= 1'b1;
        cnt <= 0;
      end else begin
        cnt <= cnt + 1;
      end
    end
  end
endmodule

//--- tb/charger_alert_status_logic_tb.sv
// self-checking bench for the charger alert and status logic
`include "charger_alert_params.svh"
module charger_alert_status_logic_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, rstn, wr, rd, ara, eq_done;
  logic [`ADDR_W-1:0] addr;
  logic [15:0] wdata, rdata, lc; // lc: limit crossing levels, bit order of the word
  logic [10:0] ph;
  logic [3:0] lp;
  logic [13:0] st; // status causes, bit order of the status word
  logic oe, o_pin;
  wire alert_line = oe ? o_pin : 1'b1; // pull-up holds the released line high
  int err_count, n_tests;
  // ==========================================================
  // design, with a short measurement cycle so ticks come every 16 clocks
  charger_alert_status_logic #(.MEAS_CYCLE_CYCLES(16)) u_dut (.clk(clk), .rstn(rstn),
    .reg_wr(wr), .reg_rd(rd), .reg_addr(addr), .reg_wdata(wdata), .reg_rdata_ff(rdata),
    .ara_done(ara), .smbalert_o_ff(o_pin), .smbalert_oe_ff(oe),
    .input_voltage_below_limit(lc[9]), .input_voltage_above_limit(lc[8]),
    .system_voltage_below_limit(lc[7]), .system_voltage_above_limit(lc[6]),
    .input_current_above_limit(lc[5]), .battery_current_below_limit(lc[4]),
    .chip_temperature_above_limit(lc[3]), .series_resistance_above_limit(lc[2]),
    .thermistor_ratio_above_limit(lc[1]), .thermistor_ratio_below_limit(lc[0]),
    .upper_limit_crossed(lc[15:10]), .charger_phase(ph), .regulation_loop(lp),
    .charging_active(st[13]), .tracking_pin(st[11]), .equalize_request_pin(st[10]),
    .equalize_finished(eq_done), .drive_supply_good(st[9]), .cell_count_invalid(st[8]),
    .charging_permitted(st[6]), .frequency_resistor_absent(st[5]),
    .thermal_shutdown(st[4]), .input_overvoltage(st[3]), .input_above_battery(st[2]),
    .internal_supply_above_switch_uvlo(st[1]), .meas_supply_good(st[0]));
  alert_host_model u_host (.clk(clk), .rstn(rstn), .alert_line(alert_line), .ara_done(ara));
  // ==========================================================
  // register access and checking tasks
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wreg(input logic [7:0] a, input logic [15:0] d);
    @(negedge clk);
    wr = 1'b1;
    addr = a;
    wdata = d;
    @(negedge clk);
    wr = 1'b0;
  endtask
  // read data is only looked at once it has settled a full cycle later
  task automatic chk_reg(input logic [7:0] a, input logic [15:0] e);
    @(negedge clk);
    rd = 1'b1;
    addr = a;
    @(negedge clk);
    rd = 1'b0;
    @(negedge clk);
    n_tests++;
    if (rdata !== e) begin
      err_count++;
      $display("wrong value at %0t: reg %h got %h want %h", $time, a, rdata, e);
    end
  endtask
  task automatic chk_line(input logic e);
    n_tests++;
    if (alert_line !== e) begin
      err_count++;
      $display("wrong value at %0t: alert line %b want %b", $time, alert_line, e);
    end
  endtask
  task automatic print_verdict();
    if (err_count == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // ==========================================================
  // clock and watchdog
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    #(25 * 20000);
    err_count++;
    print_verdict();
  end
  // ==========================================================
  // main sequence
  initial begin
    {rstn, wr, rd, eq_done, addr, wdata, lc, ph, lp, st} = '0;
    err_count = 0;
    n_tests = 0;
    cyc(6);
    rstn = 1'b1;
    chk_reg(`OFF_LIMIT_ALERTS, 16'h0000);
    lc = 16'h0020; // disabled bit must not latch
    cyc(20);
    lc = 16'h0000;
    chk_reg(`OFF_LIMIT_ALERTS, 16'h0000);
    wreg(`OFF_EN_LIMIT, 16'hffff);
    chk_reg(`OFF_EN_LIMIT, 16'hbfff);
    // each limit crossing alone, latched at a tick, kept after the cause goes
    for (int i = 0; i < 16; i++) begin
      lc = 16'h0001 << i;
      cyc(20);
      lc = 16'h0000;
      cyc(20);
      chk_reg(`OFF_LIMIT_ALERTS, (16'h0001 << i) & 16'hbfff);
      wreg(`OFF_LIMIT_ALERTS, 16'h0000);
      chk_reg(`OFF_LIMIT_ALERTS, 16'h0000);
    end
    lc = 16'h0200; // clear while the crossing still holds
    cyc(20);
    wreg(`OFF_LIMIT_ALERTS, 16'h0000);
    chk_reg(`OFF_LIMIT_ALERTS, 16'h0200);
    lc = 16'h0000;
    cyc(20);
    chk_reg(`OFF_LIMIT_ALERTS, 16'h0200);
    wreg(`OFF_EN_LIMIT, 16'h0000);
    chk_reg(`OFF_LIMIT_ALERTS, 16'h0000);
    wreg(`OFF_EN_PHASE, 16'h07ff);
    chk_reg(`OFF_EN_PHASE, 16'h07ff);
    // every charger phase entry, plus a clear while the phase persists
    for (int i = 0; i < 11; i++) begin
      ph = 11'h001 << i;
      cyc(3);
      chk_reg(`OFF_PHASE_ALERTS, 16'h0001 << i);
      wreg(`OFF_PHASE_ALERTS, 16'h0000);
      chk_reg(`OFF_PHASE_ALERTS, 16'h0001 << i);
      ph = 11'h000;
      wreg(`OFF_PHASE_ALERTS, 16'h0000);
      chk_reg(`OFF_PHASE_ALERTS, 16'h0000);
    end
    wreg(`OFF_EN_LOOP, 16'h000f);
    chk_reg(`OFF_EN_LOOP, 16'h000f);
    // each regulation loop takeover pulls the line until the host answers
    for (int i = 0; i < 4; i++) begin
      lp = 4'h1 << i;
      cyc(3);
      chk_line(1'b0);
      cyc(10);
      chk_line(1'b1);
      chk_reg(`OFF_LOOP_ALERTS, 16'h0001 << i);
      lp = 4'h0;
      wreg(`OFF_LOOP_ALERTS, 16'h0000);
    end
    // status causes one at a time; bits 12 and 7 never show
    for (int i = 0; i < 14; i++) begin
      st = 14'h0001 << i;
      cyc(3);
      chk_reg(`OFF_SYS_STATUS, (16'h0001 << i) & 16'h2f7f);
      st = 14'h0000;
      chk_reg(`OFF_SYS_STATUS, (16'h0001 << i) & 16'h0400);
      eq_done = 1'b1;
      cyc(1);
      eq_done = 1'b0;
    end
    wreg(`OFF_SYS_STATUS, 16'hffff);
    wreg(8'h00, 16'hffff);
    chk_reg(`OFF_SYS_STATUS, 16'h0000);
    chk_reg(8'h00, 16'h0000);
    // a reset in mid-run must drop the enables written above
    rstn = 1'b0;
    cyc(2);
    rstn = 1'b1;
    chk_reg(`OFF_EN_PHASE, 16'h0000);
    chk_reg(`OFF_EN_LOOP, 16'h0000);
    print_verdict();
  end
endmodule
